// File: hw/smfc_switch_regs.sv
// Functional notes
// [RULE1] Drive-node register at 0x2150, resets to zero, all drive switches open.
// [RULE2] Drive bit 7 closes drive node to front end pin 3 when set.
// [RULE3] Drive bit 6 closes drive node to sensor electrode pin when set.
// [RULE4] Drive bit 4 closes output node to counter electrode pin when set.
// [RULE5] Drive bit 3 closes output node to analog input 3 when set.
// [RULE6] Drive bit 2 closes output node to analog input 2 when set.
// [RULE7] Drive bit 1 closes output node to analog input 1 when set.
// [RULE8] Drive bit 0 closes output node to calibration resistor pin A.
// [RULE9] Negative-node register at 0x2154, resets to zero, all switches open.
// [RULE10] Negative bit 11 closes the alternate TIA shorting switch.
// [RULE11] Negative bit 10 shorts negative node to high speed TIA input.
// [RULE12] Every switch follows only its own bit, independent of the others.
// [RULE13] Full-control registers govern switches only while source select is 1.
// [RULE14] With source select 0 the grouped mux fields drive the switches.
// [RULE15] Negative bits from 9 downward each control one further switch; here bit 7 has no switch and is not stored.
// [RULE16] Upper reserved fields read zero; writing them changes no switch.
`timescale 1ns/1ns
`default_nettype none

module smfc_switch_regs (
   // Clock and reset.
   input  wire logic                        CLK_I,
   input  wire logic                        RST_I,
   // Write address channel.
   input  wire logic [smfc_pkg::ADDR_W-1:0] AXI_AWADDR_I,
   input  wire logic                        AXI_AWVALID_I,
   output logic                             AXI_AWREADY_O,
   // Write data channel.
   input  wire logic [smfc_pkg::DATA_W-1:0] AXI_WDATA_I,
   input  wire logic [smfc_pkg::STRB_W-1:0] AXI_WSTRB_I,
   input  wire logic                        AXI_WVALID_I,
   output logic                             AXI_WREADY_O,
   // Write response channel.
   output logic [1:0]                       AXI_BRESP_O,
   output logic                             AXI_BVALID_O,
   input  wire logic                        AXI_BREADY_I,
   // Read address channel.
   input  wire logic [smfc_pkg::ADDR_W-1:0] AXI_ARADDR_I,
   input  wire logic                        AXI_ARVALID_I,
   output logic                             AXI_ARREADY_O,
   // Read data channel.
   output logic [smfc_pkg::DATA_W-1:0]      AXI_RDATA_O,
   output logic [1:0]                       AXI_RRESP_O,
   output logic                             AXI_RVALID_O,
   input  wire logic                        AXI_RREADY_I,
   // Switch closures, one bit per switch, high closes.
   output logic [7:0]                       DRIVE_SW_O,
   output logic [11:0]                      NEG_SW_O
);
   import smfc_pkg::*;

   logic [31:0] drive_q;
   logic [31:0] neg_q;
   logic [31:0] group_q;
   logic        aw_held_q;
   logic [15:0] aw_addr_q;
   logic        w_held_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [7:0]  drive_sw_q;
   logic [11:0] neg_sw_q;
   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        wr_do;
   logic [15:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_hit;
   logic [7:0]  drive_sw_d;
   logic [11:0] neg_sw_d;

   // Merge new data into old data under the byte strobes and the storage mask.
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb,
                                              input logic [31:0] mask);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res & mask;
   endfunction

   // True when the address names one of the three registers.
   function automatic logic addr_mapped(input logic [15:0] a);
      return (a == DRIVE_FULL_ADDR) || (a == NEG_FULL_ADDR) || (a == GROUP_CTRL_ADDR);
   endfunction

   // Grouped drive mux: one code closes one switch, code 9 closes them all.
   function automatic logic [7:0] dmux_decode(input logic [3:0] code);
      logic [7:0] sw;
      sw = 8'h00;
      unique case (code)
         4'h1: sw[DRV_CAL_RES_A_BIT] = 1'b1;
         4'h2: sw[DRV_ANALOG_IN_1_BIT] = 1'b1;
         4'h3: sw[DRV_ANALOG_IN_2_BIT] = 1'b1;
         4'h4: sw[DRV_ANALOG_IN_3_BIT] = 1'b1;
         4'h5: sw[DRV_COUNTER_EL_BIT] = 1'b1;
         4'h7: sw[DRV_SENSOR_EL_BIT] = 1'b1;
         4'h8: sw[DRV_FRONT_END_3_BIT] = 1'b1;
         4'h9: sw = DRIVE_SW_MASK;
         default: sw = 8'h00;
      endcase
      return sw;
   endfunction

   // Grouped negative mux; the code for the unbuilt switch leaves all open.
   function automatic logic [11:0] nmux_decode(input logic [3:0] code);
      logic [11:0] sw;
      sw = 12'h000;
      unique case (code)
         4'h0: sw[NEG_TIA_BIT] = 1'b1;
         4'h1: sw[0] = 1'b1;
         4'h2: sw[1] = 1'b1;
         4'h3: sw[2] = 1'b1;
         4'h4: sw[3] = 1'b1;
         4'h5: sw[4] = 1'b1;
         4'h6: sw[5] = 1'b1;
         4'h7: sw[6] = 1'b1;
         4'h9: sw[8] = 1'b1;
         4'hA: sw[NEG_CAL_RES_B_BIT] = 1'b1;
         4'hB, 4'hC, 4'hD, 4'hE: sw[NEG_TIA_ALT_BIT] = 1'b1;
         default: sw = 12'h000;
      endcase
      return sw;
   endfunction

   // Write channel handshakes; both stall while a response waits.
   assign AXI_AWREADY_O = !aw_held_q && !bvalid_q;
   assign AXI_WREADY_O  = !w_held_q && !bvalid_q;
   assign aw_take       = AXI_AWVALID_I && AXI_AWREADY_O;
   assign w_take        = AXI_WVALID_I && AXI_WREADY_O;
   assign wr_do         = (aw_held_q || aw_take) && (w_held_q || w_take);
   assign wr_addr       = aw_held_q ? aw_addr_q : AXI_AWADDR_I;
   assign wr_data       = w_held_q ? w_data_q : AXI_WDATA_I;
   assign wr_strb       = w_held_q ? w_strb_q : AXI_WSTRB_I;
   assign wr_hit        = addr_mapped(wr_addr);

   // Hold an address or data beat that arrives ahead of its partner.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 16'h0000;
         w_held_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         aw_held_q <= (aw_held_q || aw_take) && !wr_do;
         w_held_q  <= (w_held_q || w_take) && !wr_do;
         if (aw_take) begin
            aw_addr_q <= AXI_AWADDR_I;
         end
         if (w_take) begin
            w_data_q <= AXI_WDATA_I;
            w_strb_q <= AXI_WSTRB_I;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (AXI_BREADY_I) begin
         bvalid_q <= 1'b0;
      end
   end

   assign AXI_BVALID_O = bvalid_q;
   assign AXI_BRESP_O  = bresp_q;

   // Register storage; the masks keep reserved bits at zero.
   // [RULE1] [RULE9] zero reset
   // [RULE16] reserved bits dropped
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         drive_q <= DRIVE_FULL_RST;
         neg_q   <= NEG_FULL_RST;
         group_q <= GROUP_CTRL_RST;
      end else if (wr_do) begin
         if (wr_addr == DRIVE_FULL_ADDR) begin
            drive_q <= merge_strb(drive_q, wr_data, wr_strb, DRIVE_WR_MASK);
         end
         if (wr_addr == NEG_FULL_ADDR) begin
            neg_q <= merge_strb(neg_q, wr_data, wr_strb, NEG_WR_MASK);
         end
         if (wr_addr == GROUP_CTRL_ADDR) begin
            group_q <= merge_strb(group_q, wr_data, wr_strb, GROUP_WR_MASK);
         end
      end
   end

   // Read channel: one answer at a time, data registered one cycle later.
   assign AXI_ARREADY_O = !rvalid_q;
   assign ar_take       = AXI_ARVALID_I && AXI_ARREADY_O;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rresp_q  <= addr_mapped(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
         unique case (AXI_ARADDR_I)
            DRIVE_FULL_ADDR: rdata_q <= drive_q;
            NEG_FULL_ADDR:   rdata_q <= neg_q;
            GROUP_CTRL_ADDR: rdata_q <= group_q;
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end else if (AXI_RREADY_I) begin
         rvalid_q <= 1'b0;
      end
   end

   assign AXI_RVALID_O = rvalid_q;
   assign AXI_RDATA_O  = rdata_q;
   assign AXI_RRESP_O  = rresp_q;

   // Pick the switch source. The grouped path closes one switch at a time, or every
   // drive switch with drive code 9, so software needing odd combinations must use the full path.
   always_comb begin
      // [RULE13] full path selected
      if (group_q[SRC_SEL_BIT]) begin
         // [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] bit per switch
         // [RULE12] independent bits
         drive_sw_d = drive_q[7:0] & DRIVE_SW_MASK;
         // [RULE10] [RULE11] [RULE15] negative bits
         neg_sw_d   = neg_q[11:0] & NEG_SW_MASK;
      end else begin
         // [RULE14] grouped mux path
         drive_sw_d = dmux_decode(group_q[DMUX_LSB +: 4]);
         neg_sw_d   = nmux_decode(group_q[NMUX_LSB +: 4]);
      end
   end

   // Registered switch drive so the analog controls never see a glitch.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         drive_sw_q <= 8'h00;
         neg_sw_q   <= 12'h000;
      end else begin
         drive_sw_q <= drive_sw_d;
         neg_sw_q   <= neg_sw_d;
      end
   end

   assign DRIVE_SW_O = drive_sw_q;
   assign NEG_SW_O   = neg_sw_q;

   // Checks on the register bank and the switch outputs.
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   drive_reset_a: assert property ($fell(RST_I) |-> drive_q == DRIVE_FULL_RST) // [RULE1]
      else $error("Drive register not zero after reset.");

   neg_reset_a: assert property ($fell(RST_I) |-> neg_q == NEG_FULL_RST && NEG_SW_O == 12'h000) // [RULE9]
      else $error("Negative register not zero after reset.");

   front_end_sw_a: assert property (group_q[SRC_SEL_BIT] && $stable(group_q) // [RULE2]
         |=> DRIVE_SW_O[DRV_FRONT_END_3_BIT] == $past(drive_q[DRV_FRONT_END_3_BIT]))
      else $error("Front end switch does not follow its bit.");

   drive_full_map_a: assert property (group_q[SRC_SEL_BIT] // [RULE12]
         |=> DRIVE_SW_O == ($past(drive_q[7:0]) & DRIVE_SW_MASK))
      else $error("Drive switches do not follow the full register.");

   tia_sw_a: assert property (group_q[SRC_SEL_BIT] && neg_q[NEG_TIA_BIT] // [RULE11]
         |=> NEG_SW_O[NEG_TIA_BIT])
      else $error("TIA short switch not closed.");

   tia_alt_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE10]
         |=> NEG_SW_O[NEG_TIA_ALT_BIT] == $past(neg_q[NEG_TIA_ALT_BIT]))
      else $error("Alternate TIA switch does not follow its bit.");

   group_path_a: assert property (!group_q[SRC_SEL_BIT] && group_q[3:0] == 4'h9 // [RULE14]
         |=> DRIVE_SW_O == DRIVE_SW_MASK)
      else $error("Grouped code nine does not close all drive switches.");

   reserved_zero_a: assert property ((drive_q & ~DRIVE_WR_MASK) == 32'h0000_0000 // [RULE16]
         && (neg_q & ~NEG_WR_MASK) == 32'h0000_0000)
      else $error("Reserved bits hold a nonzero value.");

   write_lands_a: assert property (wr_do && wr_addr == DRIVE_FULL_ADDR // [RULE12]
         && wr_strb == 4'hF |=> drive_q == ($past(wr_data) & DRIVE_WR_MASK) ##0 bvalid_q)
      else $error("Full write to drive register lost.");

   // The answer carries the register as it stood when the address was taken.
   read_answer_a: assert property (ar_take && AXI_ARADDR_I == DRIVE_FULL_ADDR // [RULE16]
         |=> rvalid_q && rdata_q == ($past(drive_q) & DRIVE_WR_MASK))
      else $error("Read answer not given one cycle after the address.");

   sensor_el_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE3]
         |=> DRIVE_SW_O[DRV_SENSOR_EL_BIT] == $past(drive_q[DRV_SENSOR_EL_BIT]))
      else $error("Sensor electrode switch does not follow its bit.");

   counter_el_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE4]
         |=> DRIVE_SW_O[DRV_COUNTER_EL_BIT] == $past(drive_q[DRV_COUNTER_EL_BIT]))
      else $error("Counter electrode switch does not follow its bit.");

   analog_in_3_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE5]
         |=> DRIVE_SW_O[DRV_ANALOG_IN_3_BIT] == $past(drive_q[DRV_ANALOG_IN_3_BIT]))
      else $error("Analog input 3 switch does not follow its bit.");

   analog_in_2_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE6]
         |=> DRIVE_SW_O[DRV_ANALOG_IN_2_BIT] == $past(drive_q[DRV_ANALOG_IN_2_BIT]))
      else $error("Analog input 2 switch does not follow its bit.");

   analog_in_1_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE7]
         |=> DRIVE_SW_O[DRV_ANALOG_IN_1_BIT] == $past(drive_q[DRV_ANALOG_IN_1_BIT]))
      else $error("Analog input 1 switch does not follow its bit.");

   cal_res_sw_a: assert property (group_q[SRC_SEL_BIT] // [RULE8]
         |=> DRIVE_SW_O[DRV_CAL_RES_A_BIT] == $past(drive_q[DRV_CAL_RES_A_BIT]))
      else $error("Calibration resistor switch does not follow its bit.");

   neg_full_map_a: assert property (group_q[SRC_SEL_BIT] // [RULE15]
         |=> NEG_SW_O == ($past(neg_q[11:0]) & NEG_SW_MASK))
      else $error("Negative switches do not follow the full register.");

   // The grouped path must close exactly one switch for a single-switch code.
   neg_group_a: assert property (!group_q[SRC_SEL_BIT] // [RULE14]
         && group_q[NMUX_LSB +: 4] == 4'hA |=> NEG_SW_O[NEG_CAL_RES_B_BIT] && $onehot(NEG_SW_O))
      else $error("Grouped negative code does not close its one switch.");

   // With the grouped path chosen, set full-control bits must not leak through.
   full_ignored_a: assert property (!group_q[SRC_SEL_BIT] // [RULE13]
         && group_q[DMUX_LSB +: 4] == 4'hF |=> DRIVE_SW_O == 8'h00)
      else $error("Full-control bits reach the switches in grouped mode.");

   spare_open_a: assert property ((DRIVE_SW_O & ~DRIVE_SW_MASK) == 8'h00 // [RULE16]
         && (NEG_SW_O & ~NEG_SW_MASK) == 12'h000)
      else $error("A position without a switch is driven high.");

   src_select_cov: cover property (group_q[SRC_SEL_BIT] ##1 !group_q[SRC_SEL_BIT]);
   neg_full_cov: cover property (group_q[SRC_SEL_BIT] && neg_q[NEG_TIA_BIT] && neg_q[0]);
   split_write_cov: cover property (w_take && !aw_take ##[1:4] aw_take);
   bad_addr_cov: cover property (bvalid_q && bresp_q == RESP_SLVERR);
   group_alt_cov: cover property (!group_q[SRC_SEL_BIT] && group_q[NMUX_LSB +: 4] == 4'hB);

endmodule

`default_nettype wire

// File: hw/smfc_pkg.sv
// Shared constants for the switch-matrix full-control register bank.
package smfc_pkg;

   // Bus geometry.
   localparam int          ADDR_W = 16;
   localparam int          DATA_W = 32;
   localparam int          STRB_W = DATA_W / 8;

   // Register byte addresses.
   localparam logic [15:0] DRIVE_FULL_ADDR = 16'h2150;
   localparam logic [15:0] NEG_FULL_ADDR   = 16'h2154;
   localparam logic [15:0] GROUP_CTRL_ADDR = 16'h2160;

   // Reset values.
   localparam logic [31:0] DRIVE_FULL_RST = 32'h0000_0000;
   localparam logic [31:0] NEG_FULL_RST   = 32'h0000_0000;
   localparam logic [31:0] GROUP_CTRL_RST = 32'h0000_0F0F;

   // Bits that hold storage; every other bit reads as zero.
   localparam logic [31:0] DRIVE_WR_MASK = 32'h0000_00FF;
   localparam logic [31:0] NEG_WR_MASK   = 32'h0000_0F7F;
   localparam logic [31:0] GROUP_WR_MASK = 32'h0001_0F0F;

   // Bits that reach a switch.
   localparam logic [7:0]  DRIVE_SW_MASK = 8'hDF;
   localparam logic [11:0] NEG_SW_MASK   = 12'hF7F;

   // Drive-node switch positions.
   localparam int DRV_FRONT_END_3_BIT = 7;
   localparam int DRV_SENSOR_EL_BIT   = 6;
   localparam int DRV_COUNTER_EL_BIT  = 4;
   localparam int DRV_ANALOG_IN_3_BIT = 3;
   localparam int DRV_ANALOG_IN_2_BIT = 2;
   localparam int DRV_ANALOG_IN_1_BIT = 1;
   localparam int DRV_CAL_RES_A_BIT   = 0;

   // Negative-node switch positions.
   localparam int NEG_TIA_ALT_BIT   = 11;
   localparam int NEG_TIA_BIT       = 10;
   localparam int NEG_CAL_RES_B_BIT = 9;

   // Grouped control fields.
   localparam int SRC_SEL_BIT = 16;
   localparam int NMUX_LSB    = 8;
   localparam int DMUX_LSB    = 0;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: test/smfc_switch_regs_test.sv
`timescale 1ns/1ns
`default_nettype none

module smfc_switch_regs_test;
   import smfc_pkg::*;

   // Bench-driven stimulus and the design's answers.
   logic              clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [STRB_W-1:0] wstrb;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic [7:0]        drive_sw;
   logic [11:0]       neg_sw;
   int                errors, n_tests;
   // Expected grouped decode for every mux code, drive node and negative node.
   logic [7:0]  drv_dec [16] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h40,
                                 8'h80, 8'hDF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [11:0] neg_dec [16] = '{12'h400, 12'h001, 12'h002, 12'h004, 12'h008, 12'h010,
                                 12'h020, 12'h040, 12'h000, 12'h100, 12'h200, 12'h800,
                                 12'h800, 12'h800, 12'h800, 12'h000};

   smfc_switch_regs smfc_switch_regs_i (
      .CLK_I(clk), .RST_I(rst),
      .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
      .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
      .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
      .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
      .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
      .DRIVE_SW_O(drive_sw), .NEG_SW_O(neg_sw));

   // Free-running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One write. Readies are sampled at the falling edge, so the decision never races the
   // design's own updates at the rising edge where the transfer happens.
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                            input logic [3:0] s, input logic [1:0] er);
      logic       aw_p, w_p, b_p, ta, tw, tb;
      logic [1:0] resp;
      int         n;
      aw_p = 1'b1;
      w_p = 1'b1;
      b_p = 1'b1;
      n = 0;
      resp = 2'b11;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while ((aw_p || w_p || b_p) && n < 40) begin
         @(negedge clk);
         ta = aw_p && awready;
         tw = w_p && wready;
         tb = b_p && !aw_p && !w_p && bvalid;
         if (tb) begin
            resp = bresp;
         end
         @(posedge clk);
         awvalid <= aw_p && !ta;
         aw_p = aw_p && !ta;
         wvalid <= w_p && !tw;
         w_p = w_p && !tw;
         bready <= b_p && !tb;
         b_p = b_p && !tb;
         n++;
      end
      chk({30'h0, resp}, {30'h0, er});
      @(posedge clk);
   endtask

   // One read, compared with the expected data and response.
   task automatic rd_is(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic        ar_p, r_p, ta, tr;
      logic [31:0] d;
      logic [1:0]  resp;
      int          n;
      ar_p = 1'b1;
      r_p = 1'b1;
      n = 0;
      d = 32'hDEAD_BEEF;
      resp = 2'b11;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while ((ar_p || r_p) && n < 40) begin
         @(negedge clk);
         ta = ar_p && arready;
         tr = r_p && !ar_p && rvalid;
         if (tr) begin
            d = rdata;
            resp = rresp;
         end
         @(posedge clk);
         arvalid <= ar_p && !ta;
         ar_p = ar_p && !ta;
         rready <= r_p && !tr;
         r_p = r_p && !tr;
         n++;
      end
      chk(d, ed);
      chk({30'h0, resp}, {30'h0, er});
      @(posedge clk);
   endtask

   // Switch outputs are looked at mid-cycle, once the register stage has landed.
   task automatic sw_is(input logic [7:0] d, input logic [11:0] ng);
      @(negedge clk);
      chk({24'h0, drive_sw}, {24'h0, d});
      chk({20'h0, neg_sw}, {20'h0, ng});
      @(posedge clk);
   endtask

   // Main sequence of register accesses and switch checks.
   initial begin
      errors = 0;
      n_tests = 0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 16'h0000;
      araddr = 16'h0000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sw_is(8'h00, 12'h000);
      rd_is(DRIVE_FULL_ADDR, 32'h0000_0000, RESP_OKAY);
      rd_is(NEG_FULL_ADDR, 32'h0000_0000, RESP_OKAY);
      axi_write(GROUP_CTRL_ADDR, 32'h0001_0F0F, 4'hF, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         axi_write(DRIVE_FULL_ADDR, 32'h1 << i, 4'hF, RESP_OKAY);
         sw_is((8'h01 << i) & 8'hDF, 12'h000);
         rd_is(DRIVE_FULL_ADDR, 32'h1 << i, RESP_OKAY);
      end
      for (int i = 0; i < 12; i++) begin
         axi_write(NEG_FULL_ADDR, 32'h1 << i, 4'hF, RESP_OKAY);
         sw_is(8'h80, (12'h001 << i) & 12'hF7F);
         rd_is(NEG_FULL_ADDR, (32'h1 << i) & 32'h0000_0F7F, RESP_OKAY);
      end
      // All ones, reserved bits included: they read back zero and close nothing.
      axi_write(DRIVE_FULL_ADDR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      axi_write(NEG_FULL_ADDR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      sw_is(8'hDF, 12'hF7F);
      rd_is(DRIVE_FULL_ADDR, 32'h0000_00FF, RESP_OKAY);
      rd_is(NEG_FULL_ADDR, 32'h0000_0F7F, RESP_OKAY);
      // A byte-masked write opens only the switches of negative bits 8 to 11, both shorting switches among them.
      axi_write(NEG_FULL_ADDR, 32'h0000_0000, 4'b0010, RESP_OKAY);
      sw_is(8'hDF, 12'h07F);
      // An unmapped place is refused and disturbs nothing.
      axi_write(16'h2158, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      rd_is(16'h2158, 32'h0000_0000, RESP_SLVERR);
      sw_is(8'hDF, 12'h07F);
      // Grouped mode: the full-control bits stay stored but are ignored.
      for (int i = 0; i < 16; i++) begin
         axi_write(GROUP_CTRL_ADDR, {20'h0_0000, 4'(i), 4'h0, 4'(i)}, 4'hF, RESP_OKAY);
         sw_is(drv_dec[i], neg_dec[i]);
      end
      axi_write(GROUP_CTRL_ADDR, 32'h0001_0F0F, 4'hF, RESP_OKAY);
      sw_is(8'hDF, 12'h07F);
      // Reset in mid-run clears both registers and opens every switch.
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sw_is(8'h00, 12'h000);
      rd_is(DRIVE_FULL_ADDR, 32'h0000_0000, RESP_OKAY);
      rd_is(NEG_FULL_ADDR, 32'h0000_0000, RESP_OKAY);
      wrap_up();
   end

   // Watchdog: the sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      wrap_up();
   end
endmodule

`default_nettype wire
